// File: src/svbd_synth_ctrl.sv
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// - Bank selects oscillator and LO divide
// - 128 bands chosen automatically from active bank
// - Chip enable rise starts band search
// - Band result readable; 0 or 127 fails
// - Search lasts about 1500 detector cycles
// - Stored band used when calibration disabled
// - LO divide from bank control word
// - LO routed by mode pin, duplex bit
// - Bypass divides by one, else 2..7
// - Two banks, mode pin picks active one
// - Loop target uses fraction and ref divider
// - Set pump current 120uA, low 30uA
// - Pump current scaled by field over 31
// - Auto bandwidth lets calibration pick current
// - Detector accepts up to 52MHz input
// - Mode low bank one; duplex both mixers
module svbd_synth_ctrl
  import svbd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chip_enable_pin,
  input  wire logic        mode_pin,
  input  wire logic        ref_tick,
  input  wire logic        osc_too_fast,
  input  wire logic [4:0]  measured_gain_scale,
  output logic             pd_tick,
  output logic             bank_two_active,
  output logic             mixer1_lo_en,
  output logic             mixer2_lo_en,
  output logic [1:0]       osc_select,
  output logic [1:0]       lo_divide,
  output logic [6:0]       osc_band,
  output logic [4:0]       coarse_tune_voltage,
  output logic             cal_busy,
  output logic             loop_lock_en,
  output logic [9:0]       integer_divider,
  output logic [23:0]      fraction_word,
  output logic [7:0]       pump_current_ua,
  output logic [1:0]       freq_lock_factor,
  output logic [3:0]       lo_buffer1_current,
  output logic [3:0]       lo_buffer2_current
);

  // Shared configuration fields
  logic             both_mixers_bit;      // Full duplex routing
  logic             ref_divider_bypass;   // Divide reference by one
  logic [2:0]       ref_div_code;         // Reference divide 2..7
  logic             pump_low_current_bit; // Quarter set current
  logic             auto_bw_enable;       // Loop bandwidth correction
  logic [1:0]       flf_reg;              // Lock factor field
  logic [3:0]       lobuf1_reg;           // LO buffer 1 current
  logic [3:0]       lobuf2_reg;           // LO buffer 2 current

  // Per-bank programming words, index 0 is bank one
  logic [1:0]       bank_osc       [2];
  logic [1:0]       bank_lodiv     [2];
  logic             bank_cal_en    [2];
  logic [6:0]       bank_def_band  [2];
  logic [4:0]       bank_ctv       [2];
  logic [4:0]       bank_pump      [2];
  logic [9:0]       bank_int       [2];
  logic [23:0]      bank_frac      [2];

  // Calibration machinery
  svbd_state_t      state;            // Search state
  svbd_state_t      next_state;       // Next search state
  logic             ce_q;             // Previous chip enable level
  logic [2:0]       rdiv_cnt;         // Reference tick counter
  logic [7:0]       step_cnt;         // Detector cycles in this step
  logic [2:0]       bit_idx;          // Band bit under trial
  logic [6:0]       trial_band;       // Band being tried
  logic [6:0]       band_result_readback; // Published search result
  logic             result_done;      // A search has completed

  // Bus decode
  wire              bus_access  = psel & penable & pready;
  wire              bus_write   = bus_access & pwrite;
  wire              hit_bank1   = (paddr[7:4] == ADDR_BANK1[7:4]);
  wire              hit_bank2   = (paddr[7:4] == ADDR_BANK2[7:4]);
  wire              hit_bank    = hit_bank1 | hit_bank2;
  wire              widx        = hit_bank2;
  wire [7:0]        bank_ofs    = {4'h0, paddr[3:0]};
  wire              sel_cfg     = (paddr == ADDR_CFG);
  wire              sel_lobuf   = (paddr == ADDR_LOBUF);
  wire              sel_rb      = (paddr == ADDR_READBACK);
  wire              sel_bctrl   = hit_bank & (bank_ofs == BANK_CTRL_OFS);
  wire              sel_bint    = hit_bank & (bank_ofs == BANK_INT_OFS);
  wire              sel_bfrac   = hit_bank & (bank_ofs == BANK_FRAC_OFS);
  wire              addr_ok     = sel_cfg | sel_lobuf | sel_rb | sel_bctrl | sel_bint | sel_bfrac;

  // Active bank follows the mode pin
  wire              abank       = mode_pin;

  // Read data selection
  wire [31:0]       rd_cfg      = {16'h0000, ref_div_code, ref_divider_bypass, 6'h00, flf_reg,
                                   auto_bw_enable, pump_low_current_bit, 1'b0, both_mixers_bit};
  wire [31:0]       rd_lobuf    = {24'h00_0000, lobuf2_reg, lobuf1_reg};
  wire [31:0]       rd_bctrl    = {3'h0, bank_pump[widx], 3'h0, bank_ctv[widx], 1'b0, bank_def_band[widx],
                                   3'h0, bank_cal_en[widx], bank_lodiv[widx], bank_osc[widx]};
  wire [31:0]       rd_rb       = {21'h00_0000, result_done, cal_busy,
                                   result_done & ((band_result_readback == BAND_LOW_FAIL) |
                                   (band_result_readback == BAND_HIGH_FAIL)), 1'b0, band_result_readback};
  wire [31:0]       rd_word     = sel_cfg   ? rd_cfg :
                                  sel_lobuf ? rd_lobuf :
                                  sel_rb    ? rd_rb :
                                  sel_bctrl ? rd_bctrl :
                                  sel_bint  ? {22'h00_0000, bank_int[widx]} :
                                  sel_bfrac ? {8'h00, bank_frac[widx]} : 32'h0000_0000;

  // Ready registered from the setup phase lets read data come from a flop with no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      prdata  <= rd_word;
      pslverr <= psel & ~penable & ~addr_ok;
    end
  end

  // Shared configuration writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      both_mixers_bit      <= 1'b0;
      ref_divider_bypass   <= 1'b0;
      ref_div_code         <= RDIV_RESET;
      pump_low_current_bit <= 1'b0;
      auto_bw_enable       <= 1'b0;
      flf_reg              <= FLF_RESET;
      lobuf1_reg           <= LOBUF_RESET;
      lobuf2_reg           <= LOBUF_RESET;
    end
    else if (bus_write && sel_cfg)
    begin
      both_mixers_bit      <= pwdata[CFG_BOTH_MIX];
      ref_divider_bypass   <= pwdata[CFG_BYPASS];
      ref_div_code         <= pwdata[CFG_RDIV_LSB +: 3];
      pump_low_current_bit <= pwdata[CFG_PUMP_LOW];
      auto_bw_enable       <= pwdata[CFG_AUTO_BW];
      flf_reg              <= pwdata[CFG_FLF_LSB +: 2];
    end
    else if (bus_write && sel_lobuf)
    begin
      lobuf1_reg <= pwdata[LOBUF1_LSB +: 4];
      lobuf2_reg <= pwdata[LOBUF2_LSB +: 4];
    end
  end

  // Per-bank writes, one block for both banks indexed by widx
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int b = 0; b < 2; b++)
      begin
        bank_osc[b]      <= OSC_RESET;
        bank_lodiv[b]    <= LODIV_RESET;
        bank_cal_en[b]   <= 1'b1;
        bank_def_band[b] <= DEFBAND_RESET;
        bank_ctv[b]      <= CTV_RESET;
        bank_pump[b]     <= PUMP_RESET;
        bank_int[b]      <= 10'h000;
        bank_frac[b]     <= 24'h00_0000;
      end
    end
    else if (bus_write && sel_bctrl)
    begin
      bank_osc[widx]      <= pwdata[BK_OSC_LSB +: 2];
      bank_lodiv[widx]    <= pwdata[BK_LODIV_LSB +: 2];
      bank_cal_en[widx]   <= pwdata[BK_CALEN];
      bank_def_band[widx] <= pwdata[BK_DEFBAND_LSB +: 7];
      bank_ctv[widx]      <= pwdata[BK_CTV_LSB +: 5];
      bank_pump[widx]     <= pwdata[BK_PUMP_LSB +: 5];
    end
    else if (bus_write && sel_bint)
    begin
      bank_int[widx] <= pwdata[9:0];
    end
    else if (bus_write && sel_bfrac)
    begin
      bank_frac[widx] <= pwdata[23:0];
    end
  end

  // Reference divider; bypass gives divide by one
  wire [2:0]        rdiv_last   = ref_divider_bypass ? 3'h0 : (ref_div_code - 3'h1);
  wire              pd_edge     = ref_tick & (rdiv_cnt >= rdiv_last);

  // Divider counter and detector tick register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdiv_cnt <= 3'h0;
      pd_tick  <= 1'b0;
    end
    else
    begin
      pd_tick <= pd_edge;
      if (pd_edge)
        rdiv_cnt <= 3'h0;
      else if (ref_tick)
        rdiv_cnt <= rdiv_cnt + 3'h1;
    end
  end

  // Search control
  wire              ce_rise     = chip_enable_pin & ~ce_q;
  wire              step_end    = pd_edge & (step_cnt == STEP_LAST);
  wire              last_bit    = (bit_idx == 3'h0);
  wire [6:0]        bit_mask    = 7'h01 << bit_idx;
  wire [6:0]        kept_band   = osc_too_fast ? trial_band : (trial_band & ~bit_mask);
  wire [6:0]        next_trial  = kept_band | (bit_mask >> 1);

  // Next state of the band search
  always_comb
  begin
    next_state = state;
    case (state)
      SVBD_IDLE:
        if (ce_rise)
          next_state = bank_cal_en[abank] ? SVBD_SEARCH : SVBD_LOCK;
      SVBD_SEARCH:
        if (!chip_enable_pin)
          next_state = SVBD_IDLE;
        else if (step_end && last_bit)
          next_state = SVBD_LOCK;
      SVBD_LOCK:
        if (!chip_enable_pin)
          next_state = SVBD_IDLE;
      default:
        next_state = SVBD_IDLE;
    endcase
  end

  // Search registers; a dropped enable abandons the search
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state                <= SVBD_IDLE;
      ce_q                 <= 1'b0;
      step_cnt             <= 8'h00;
      bit_idx              <= 3'h0;
      trial_band           <= BAND_MID;
      osc_band             <= BAND_MID;
      band_result_readback <= BAND_LOW_FAIL;
      result_done          <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ce_q  <= chip_enable_pin;
      if (state == SVBD_IDLE && ce_rise)
      begin
        step_cnt    <= 8'h00;
        bit_idx     <= 3'(BAND_BITS - 1);
        trial_band  <= BAND_MID;
        osc_band    <= bank_cal_en[abank] ? BAND_MID : bank_def_band[abank];
        result_done <= 1'b0;
      end
      else if (state == SVBD_SEARCH && pd_edge)
      begin
        step_cnt <= step_end ? 8'h00 : step_cnt + 8'h01;
        if (step_end)
        begin
          trial_band <= last_bit ? kept_band : next_trial;
          osc_band   <= last_bit ? kept_band : next_trial;
          bit_idx    <= bit_idx - 3'h1;
          if (last_bit)
          begin
            band_result_readback <= kept_band;
            result_done          <= 1'b1;
          end
        end
      end
    end
  end

  // Pump current from set current and scale over 31
  wire [4:0]        pump_scale  = auto_bw_enable ? measured_gain_scale : bank_pump[abank];
  wire [7:0]        set_ua      = pump_low_current_bit ? 8'(PUMP_LOW_UA) : 8'(PUMP_FULL_UA);
  wire [12:0]       pump_prod   = set_ua * pump_scale;
  wire [12:0]       pump_quot   = pump_prod / 13'(PUMP_SCALE_DEN);

  // Oscillator select; unused codes fall back to the last oscillator
  wire [1:0]        osc_pick    = (bank_osc[abank] > OSC_LAST) ? OSC_LAST : bank_osc[abank];
  wire [1:0]        lodiv_pick  = (bank_lodiv[abank] > LODIV_FOUR) ? LODIV_FOUR : bank_lodiv[abank];

  // Registered outputs of the active bank and routing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_two_active     <= 1'b0;
      mixer1_lo_en        <= 1'b0;
      mixer2_lo_en        <= 1'b0;
      osc_select          <= OSC_RESET;
      lo_divide           <= LODIV_RESET;
      coarse_tune_voltage <= CTV_RESET;
      cal_busy            <= 1'b0;
      loop_lock_en        <= 1'b0;
      integer_divider     <= 10'h000;
      fraction_word       <= 24'h00_0000;
      pump_current_ua     <= 8'h00;
      freq_lock_factor    <= FLF_RESET;
      lo_buffer1_current  <= LOBUF_RESET;
      lo_buffer2_current  <= LOBUF_RESET;
    end
    else
    begin
      bank_two_active     <= abank;
      mixer1_lo_en        <= ~abank | both_mixers_bit;
      mixer2_lo_en        <= abank | both_mixers_bit;
      osc_select          <= osc_pick;
      lo_divide           <= lodiv_pick;
      coarse_tune_voltage <= bank_ctv[abank];
      cal_busy            <= (next_state == SVBD_SEARCH);
      loop_lock_en        <= (next_state == SVBD_LOCK);
      integer_divider     <= bank_int[abank];
      fraction_word       <= bank_frac[abank];
      pump_current_ua     <= pump_quot[7:0];
      freq_lock_factor    <= flf_reg;
      lo_buffer1_current  <= lobuf1_reg;
      lo_buffer2_current  <= lobuf2_reg;
    end
  end

endmodule : svbd_synth_ctrl

// File: shared/svbd_pkg.sv
package svbd_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CFG       = 8'h00;
  localparam logic [7:0] ADDR_LOBUF     = 8'h04;
  localparam logic [7:0] ADDR_BANK1     = 8'h10;
  localparam logic [7:0] ADDR_BANK2     = 8'h20;
  localparam logic [7:0] ADDR_READBACK  = 8'h30;
  localparam logic [7:0] BANK_CTRL_OFS  = 8'h00;
  localparam logic [7:0] BANK_INT_OFS   = 8'h04;
  localparam logic [7:0] BANK_FRAC_OFS  = 8'h08;
  // Configuration word fields
  localparam int CFG_BOTH_MIX   = 0;
  localparam int CFG_PUMP_LOW   = 2;
  localparam int CFG_AUTO_BW    = 3;
  localparam int CFG_FLF_LSB    = 4;
  localparam int CFG_BYPASS     = 12;
  localparam int CFG_RDIV_LSB   = 13;
  // LO buffer word fields
  localparam int LOBUF1_LSB     = 0;
  localparam int LOBUF2_LSB     = 4;
  // Bank control word fields
  localparam int BK_OSC_LSB     = 0;
  localparam int BK_LODIV_LSB   = 2;
  localparam int BK_CALEN       = 4;
  localparam int BK_DEFBAND_LSB = 8;
  localparam int BK_CTV_LSB     = 16;
  localparam int BK_PUMP_LSB    = 24;
  // Read-back word fields
  localparam int RB_FAIL        = 8;
  localparam int RB_BUSY        = 9;
  localparam int RB_DONE        = 10;
  // Reset values
  localparam logic [1:0]  FLF_RESET      = 2'h1;
  localparam logic [2:0]  RDIV_RESET     = 3'h2;
  localparam logic [4:0]  PUMP_RESET     = 5'h1f;
  localparam logic [4:0]  CTV_RESET      = 5'h10;
  localparam logic [3:0]  LOBUF_RESET    = 4'h0;
  localparam logic [1:0]  OSC_RESET      = 2'h0;
  localparam logic [1:0]  LODIV_RESET    = 2'h1;
  localparam logic [6:0]  DEFBAND_RESET  = 7'h40;
  // LO divider codes and last oscillator code
  localparam logic [1:0]  LODIV_DIRECT   = 2'h0;
  localparam logic [1:0]  LODIV_TWO      = 2'h1;
  localparam logic [1:0]  LODIV_FOUR     = 2'h2;
  localparam logic [1:0]  OSC_LAST       = 2'h2;
  // Band search
  localparam logic [6:0]  BAND_MID       = 7'h40;
  localparam logic [6:0]  BAND_LOW_FAIL  = 7'h00;
  localparam logic [6:0]  BAND_HIGH_FAIL = 7'h7f;
  localparam int          BAND_BITS      = 7;
  localparam int          CAL_PD_CYCLES  = 1500;
  localparam int          STEP_PD_CYCLES = CAL_PD_CYCLES / BAND_BITS;
  localparam logic [7:0]  STEP_LAST      = 8'(STEP_PD_CYCLES - 1);
  // Charge pump set currents in microamps
  localparam int          PUMP_FULL_UA   = 120;
  localparam int          PUMP_LOW_UA    = 30;
  localparam int          PUMP_SCALE_DEN = 31;
  // Calibration states
  typedef enum logic [1:0] {SVBD_IDLE, SVBD_SEARCH, SVBD_LOCK} svbd_state_t;
endpackage : svbd_pkg

// File: verification/svbd_synth_monitor.sv
`timescale 1ns/10ps
// Port-level checker for the synthesizer control block
module svbd_synth_monitor
  import svbd_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       chip_enable_pin,
  input wire logic       mode_pin,
  input wire logic       pd_tick,
  input wire logic       bank_two_active,
  input wire logic       mixer1_lo_en,
  input wire logic       mixer2_lo_en,
  input wire logic [1:0] osc_select,
  input wire logic [1:0] lo_divide,
  input wire logic [6:0] osc_band,
  input wire logic       cal_busy,
  input wire logic       loop_lock_en,
  input wire logic [7:0] pump_current_ua
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [11:0] busy_ticks;  // Detector ticks during a search
  // Cleared outside a search so an abort never leaks into the next count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_ticks <= 12'h000;
    else if (!cal_busy)
      busy_ticks <= 12'h000;
    else if (pd_tick)
      busy_ticks <= busy_ticks + 12'h001;
  end
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_bank; 1'b1 |=> bank_two_active == $past(mode_pin); endproperty
  a_bank: assert property (p_bank) else $error("bank not following mode");
  property p_mix; 1'b1 |=> (bank_two_active ? mixer2_lo_en : mixer1_lo_en); endproperty
  a_mix: assert property (p_mix) else $error("matching mixer off");
  property p_start; $rose(chip_enable_pin) && !cal_busy && !loop_lock_en |=> ##1 (cal_busy || loop_lock_en);
  endproperty
  a_start: assert property (p_start) else $error("enable rise ignored");
  property p_dur; $fell(cal_busy) && chip_enable_pin |-> busy_ticks >= 12'h5d2 && busy_ticks <= 12'h5dc;
  endproperty
  a_dur: assert property (p_dur) else $error("search length off");
  property p_hold; loop_lock_en && $past(loop_lock_en) |-> $stable(osc_band); endproperty
  a_hold: assert property (p_hold) else $error("band moved while locked");
  property p_pump; pump_current_ua <= 8'h78; endproperty
  a_pump: assert property (p_pump) else $error("pump current above full");
  property p_codes; osc_select != 2'h3 && lo_divide != 2'h3; endproperty
  a_codes: assert property (p_codes) else $error("illegal select code");
  c_done: cover property ($fell(cal_busy) && chip_enable_pin);
  c_err: cover property (pslverr);
  c_both: cover property (mixer1_lo_en && mixer2_lo_en);
endmodule : svbd_synth_monitor

bind svbd_synth_ctrl svbd_synth_monitor i_mon (.*);

// File: verification/svbd_host_model.sv
`timescale 1ns/10ps
// Host side: APB master that programs the block
module svbd_host_model (
  input wire logic        pclk,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [7:0]      paddr,
  output logic [31:0]     pwdata
);
  logic last_err;  // Error flag of the last transfer
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd
endmodule : svbd_host_model

// File: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import svbd_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, chip_enable_pin, mode_pin;
  logic osc_too_fast, pd_tick, bank_two_active, mixer1_lo_en, mixer2_lo_en, cal_busy, loop_lock_en;
  logic [7:0] paddr, pump_current_ua;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] osc_select, lo_divide, freq_lock_factor;
  logic [6:0] osc_band, target;  // Highest band at which the oscillator still runs fast
  logic [4:0] coarse_tune_voltage, measured_gain_scale;
  logic [9:0] integer_divider;
  logic [23:0] fraction_word;
  logic [3:0] lo_buffer1_current, lo_buffer2_current;
  int mismatches = 0;
  int check_count = 0;
  // Reference ticks every cycle keeps searches short
  svbd_synth_ctrl i_dut (.ref_tick(1'b1), .*);
  svbd_host_model i_host (.*);
  // Comparator stand-in so the search settles on target
  assign osc_too_fast = (osc_band <= target);
  always #5 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask : ticks
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic t_reset();
    // Outputs only leave their reset values one edge after release
    ticks(2);
    check({osc_band, coarse_tune_voltage, freq_lock_factor, lo_divide}, {7'h40, 5'h10, 2'h1, 2'h1});
    check(pump_current_ua, 8'h78);
    i_host.rd(ADDR_CFG, q);
    check(q, 32'h0000_4010);
    i_host.rd(ADDR_BANK1, q);
    check(q, 32'h1f10_4014);
    i_host.rd(8'h0c, q);
    check(i_host.last_err, 1'b1);
    check(q, 32'h0000_0000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_route();
    int m, b;
    i_host.wr(ADDR_BANK2, 32'h1f10_401a);
    for (m = 0; m < 2; m++)
      for (b = 0; b < 2; b++)
      begin
        i_host.wr(ADDR_CFG, 32'h0000_4010 | b);
        mode_pin <= m[0];
        ticks(3);
        check(bank_two_active, m[0]);
        check({mixer1_lo_en, mixer2_lo_en}, {!m[0] || b[0], m[0] || b[0]});
        check({osc_select, lo_divide}, m[0] ? 4'ha : 4'h1);
      end
    mode_pin <= 1'b0;
    $display("t_route done");
  endtask : t_route
  // One search; bank 1 active, result checked at pins and read-back
  task automatic t_cal(input logic [6:0] t, input logic failed);
    int i;
    target <= t;
    chip_enable_pin <= 1'b1;
    for (i = 0; i < 5000 && loop_lock_en !== 1'b1; i++)
      @(posedge pclk);
    check({loop_lock_en, osc_band}, {1'b1, t});
    i_host.rd(ADDR_READBACK, q);
    check(q, {21'h0, 3'h4 | failed, 1'b0, t});
    chip_enable_pin <= 1'b0;
    ticks(5);
    $display("t_cal done");
  endtask : t_cal
  task automatic t_setup();
    i_host.wr(ADDR_LOBUF, 32'h0000_00cc);
    i_host.wr(ADDR_BANK1, 32'h1f0c_4014);
    i_host.wr(ADDR_BANK1 + BANK_INT_OFS, 32'h0000_005c);
    i_host.wr(ADDR_BANK1 + BANK_FRAC_OFS, 32'h00cf_3284);
    i_host.wr(ADDR_CFG, 32'h0000_4000);
    ticks(2);
    check({lo_buffer1_current, lo_buffer2_current, coarse_tune_voltage, freq_lock_factor}, {8'hcc, 5'h0c, 2'h0});
    check({integer_divider, fraction_word}, {10'h05c, 24'hcf_3284});
    $display("t_setup done");
  endtask : t_setup
  // Abort then stored band: read-back must keep last result
  task automatic t_stored();
    chip_enable_pin <= 1'b1;
    ticks(100);
    check(cal_busy, 1'b1);
    chip_enable_pin <= 1'b0;
    ticks(5);
    // Band field keeps the last completed result; done cleared by the rise
    i_host.rd(ADDR_READBACK, q);
    check(q, 32'h0000_0025);
    i_host.wr(ADDR_BANK1, 32'h1f0c_3304);
    chip_enable_pin <= 1'b1;
    ticks(3);
    check({loop_lock_en, osc_band}, {1'b1, 7'h33});
    i_host.rd(ADDR_READBACK, q);
    check(q, 32'h0000_0025);
    chip_enable_pin <= 1'b0;
    $display("t_stored done");
  endtask : t_stored
  task automatic t_pump();
    i_host.wr(ADDR_BANK1, 32'h0f10_4014);
    ticks(2);
    check(pump_current_ua, 8'h3a);
    i_host.wr(ADDR_CFG, 32'h0000_4014);
    ticks(2);
    check(pump_current_ua, 8'h0e);
    i_host.wr(ADDR_CFG, 32'h0000_4018);
    ticks(2);
    check(pump_current_ua, 8'h26);
    $display("t_pump done");
  endtask : t_pump
  // Detector tick count over 420 cycles for each reference divide
  task automatic t_rdiv();
    int d, n;
    for (d = 1; d < 8; d++)
    begin
      i_host.wr(ADDR_CFG, d == 1 ? 32'h0000_1010 : (d << 13) | 32'h0000_0010);
      ticks(20);
      n = 0;
      repeat (420)
      begin
        @(posedge pclk);
        n += pd_tick;
      end
      check(n, 420 / d);
    end
    $display("t_rdiv done");
  endtask : t_rdiv
  initial
  begin
    presetn = 1'b0;
    chip_enable_pin = 1'b0;
    mode_pin = 1'b0;
    measured_gain_scale = 5'h0a;
    target = 7'h25;
    ticks(4);
    presetn <= 1'b1;
    t_reset();
    t_route();
    t_setup();
    t_cal(7'h7f, 1'b1);
    t_cal(7'h00, 1'b1);
    t_cal(7'h25, 1'b0);
    t_stored();
    t_pump();
    t_rdiv();
    summarize();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    ticks(40000);
    mismatches++;
    summarize();
  end
endmodule : tb_top
